// ---- embc_bus_ctrl.sv ----
// Purpose: external multiplexed memory bus sequencer with configurable strobe map
// Assumes: one request held stable from req_valid_i until req_ready_o
// Notes: wait states and on-chip code to data mapping are not provided
`timescale 1ns/1ps
module embc_bus_ctrl
    import embc_pkg::*;
#(
    parameter int ONCHIP_TOP = 24'hFF3FFF
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // straps
    input wire logic [7:0] config_byte_zero_i,
    input wire logic external_code_select_n_i,
    // cpu request
    input wire logic req_valid_i,
    input wire embc_req_t req_i,
    output logic req_ready_o,
    output logic onchip_o,
    output logic [7:0] rdata_o,
    // general purpose port bit shared with the data-read pin
    input wire logic port3_bit7_i,
    // external bus
    output logic [7:0] low_addr_data_bus_o,
    output logic low_addr_data_bus_oe_o,
    input wire logic [7:0] low_addr_data_bus_i,
    output logic [7:0] high_addr_lines_o,
    output logic high_addr_lines_oe_o,
    input wire logic [7:0] high_addr_lines_i,
    output logic addr_latch_o,
    output logic code_read_strobe_n_o,
    output logic data_read_n_o,
    output logic write_strobe_n_o,
    output logic addr_bit_seventeen_en_o,
    output logic [4:0] addr_pin_count_o
);
    initial begin
        if (ONCHIP_TOP < 24'hFF0000 || ONCHIP_TOP > 24'hFFFFFF)
            $error("embc_bus_ctrl: ONCHIP_TOP outside code region");
    end

    typedef enum {ST_IDLE, ST_ADDR, ST_STROBE, ST_DONE} embc_state_t;

    embc_cfg_t cfg;
    logic cfg_valid;

    embc_cfg_latch u_cfg (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .config_byte_zero_i(config_byte_zero_i),
        .external_code_select_n_i(external_code_select_n_i),
        .cfg_o(cfg),
        .cfg_valid_o(cfg_valid)
    );

    function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                      input logic [23:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // strobe map shared by the sequencer and the page-hit shortcut; map 00 strobes no read
    function automatic logic code_sel(input logic [1:0] m, input logic [23:0] a);
        code_sel = (m == MAP_A16) || (m == MAP_PORT) ||
                   ((m == MAP_SPLIT) && (a >= CODE_READ_BASE));
    endfunction

    function automatic logic data_sel(input logic [1:0] m, input logic [23:0] a);
        data_sel = (m == MAP_SPLIT) && (a <= DATA_READ_TOP);
    endfunction

    embc_state_t state_r, state_nxt;
    embc_req_t req_r, req_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] p0_r, p0_nxt, p2_r, p2_nxt;
    logic p0_oe_r, p0_oe_nxt, p2_oe_r, p2_oe_nxt;
    logic ale_r, ale_nxt, code_n_r, code_n_nxt, rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt;
    logic onchip_r, onchip_nxt;
    logic [1:0] hold_r, hold_nxt;
    logic take, go_onchip, use_code, use_rd, use_wr, page_hit_r, page_hit_nxt;
    logic [7:0] last_hi_r, last_hi_nxt;
    logic last_ok_r, last_ok_nxt;

    // on-chip code only when select strapped high and address in range
    assign go_onchip = req_i.code && !cfg.ext_code_only &&
                       in_range(req_i.addr, ONCHIP_CODE_BASE, 24'(ONCHIP_TOP));
    // valid still stands in the on-chip ready cycle; taking it again would serve it twice
    assign take = req_valid_i && cfg_valid && (state_r == ST_IDLE) && !onchip_r;

    always_comb begin
        use_code = 1'b0;
        use_rd = 1'b0;
        use_wr = 1'b0;
        if (req_r.write) begin
            if (cfg.read_map == MAP_SPLIT)
                use_wr = in_range(req_r.addr, WRITE_LOW, WRITE_HIGH);
            else
                use_wr = 1'b1;
        end else begin
            use_code = code_sel(cfg.read_map, req_r.addr);
            use_rd = data_sel(cfg.read_map, req_r.addr);
        end
    end

    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        rdata_nxt = rdata_r;
        p0_nxt = p0_r;
        p2_nxt = p2_r;
        p0_oe_nxt = p0_oe_r;
        p2_oe_nxt = p2_oe_r;
        ale_nxt = 1'b0;
        code_n_nxt = 1'b1;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        onchip_nxt = 1'b0;
        hold_nxt = hold_r;
        page_hit_nxt = page_hit_r;
        last_hi_nxt = last_hi_r;
        last_ok_nxt = last_ok_r;
        case (state_r)
            ST_IDLE: begin
                if (take && go_onchip) begin
                    onchip_nxt = 1'b1;
                end else if (take) begin
                    req_nxt = req_i;
                    p0_nxt = req_i.addr[7:0];
                    p2_nxt = req_i.addr[15:8];
                    p0_oe_nxt = 1'b1;
                    // page mode skips the latch phase when a code fetch repeats the high byte
                    page_hit_nxt = !cfg.page_sel && req_i.code && last_ok_r &&
                                   (req_i.addr[15:8] == last_hi_r);
                    // a page hit reads port 2 at once, so port 2 is released and strobed now
                    p2_oe_nxt = !page_hit_nxt;
                    code_n_nxt = !(page_hit_nxt && code_sel(cfg.read_map, req_i.addr));
                    rd_n_nxt = !(page_hit_nxt && data_sel(cfg.read_map, req_i.addr));
                    ale_nxt = !page_hit_nxt;
                    state_nxt = page_hit_nxt ? ST_STROBE : ST_ADDR;
                end
            end
            ST_ADDR: begin
                // address has been latched; free the multiplexed byte for data
                if (cfg.page_sel) begin
                    p0_nxt = req_r.wdata;
                    p0_oe_nxt = req_r.write;
                end else begin
                    p2_nxt = req_r.wdata;
                    p2_oe_nxt = req_r.write;
                end
                last_hi_nxt = req_r.addr[15:8];
                last_ok_nxt = 1'b1;
                hold_nxt = 2'(STATE_CYC - 1);
                state_nxt = ST_STROBE;
            end
            ST_STROBE: begin
                if (page_hit_r)
                    p2_oe_nxt = 1'b0;
                if (hold_r == 2'h0) begin
                    rdata_nxt = cfg.page_sel ? low_addr_data_bus_i : high_addr_lines_i;
                    state_nxt = ST_DONE;
                end else begin
                    // strobe launched a cycle ahead so data is sampled while it stands
                    code_n_nxt = !use_code;
                    rd_n_nxt = !use_rd;
                    wr_n_nxt = !use_wr;
                    hold_nxt = hold_r - 2'h1;
                end
            end
            ST_DONE: begin
                p0_oe_nxt = 1'b0;
                p2_oe_nxt = cfg.page_sel;
                page_hit_nxt = 1'b0;
                hold_nxt = 2'h0;
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= ST_IDLE;
            req_r <= '0;
            rdata_r <= 8'h00;
            p0_r <= 8'h00;
            p2_r <= 8'h00;
            p0_oe_r <= 1'b0;
            p2_oe_r <= 1'b0;
            ale_r <= 1'b0;
            code_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            onchip_r <= 1'b0;
            hold_r <= 2'h0;
            page_hit_r <= 1'b0;
            last_hi_r <= 8'h00;
            last_ok_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            rdata_r <= rdata_nxt;
            p0_r <= p0_nxt;
            p2_r <= p2_nxt;
            p0_oe_r <= p0_oe_nxt;
            p2_oe_r <= p2_oe_nxt;
            ale_r <= ale_nxt;
            code_n_r <= code_n_nxt;
            rd_n_r <= rd_n_nxt;
            wr_n_r <= wr_n_nxt;
            onchip_r <= onchip_nxt;
            hold_r <= hold_nxt;
            page_hit_r <= page_hit_nxt;
            last_hi_r <= last_hi_nxt;
            last_ok_r <= last_ok_nxt;
        end
    end

    // nonpage fetch: addr, two strobe, done = four periods; page hit: strobe, done = two
    assign req_ready_o = (state_r == ST_DONE) || onchip_r;
    assign onchip_o = onchip_r;
    assign rdata_o = rdata_r;
    assign low_addr_data_bus_o = p0_r;
    assign low_addr_data_bus_oe_o = p0_oe_r;
    assign high_addr_lines_o = p2_r;
    assign high_addr_lines_oe_o = p2_oe_r;
    assign addr_latch_o = ale_r;
    assign code_read_strobe_n_o = code_n_r;
    // the pin is address bit 16, a read strobe, or the plain port bit
    assign data_read_n_o = (cfg.read_map == MAP_A16) ? req_r.addr[16] :
                           (cfg.read_map == MAP_SPLIT) ? rd_n_r : port3_bit7_i;
    assign write_strobe_n_o = wr_n_r;
    assign addr_bit_seventeen_en_o = (cfg.read_map == MAP_A16);
    assign addr_pin_count_o = (cfg.read_map == MAP_A16) ? 5'h11 : 5'h10;
endmodule

// ---- embc_bus_ctrl_sva.sv ----
// Purpose: port checks for the external bus controller
// Assumes: straps captured at the first edge after reset, as the design does
// Notes: a private copy of the strap byte keeps checks valid if straps move later
`timescale 1ns/1ps
module embc_bus_ctrl_sva
    import embc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [7:0] config_byte_zero_i,
    input wire logic external_code_select_n_i,
    input wire embc_req_t req_i,
    input wire logic req_ready_o,
    input wire logic onchip_o,
    input wire logic port3_bit7_i,
    input wire logic [7:0] low_addr_data_bus_o,
    input wire logic low_addr_data_bus_oe_o,
    input wire logic [7:0] high_addr_lines_o,
    input wire logic high_addr_lines_oe_o,
    input wire logic addr_latch_o,
    input wire logic code_read_strobe_n_o,
    input wire logic data_read_n_o,
    input wire logic write_strobe_n_o,
    input wire logic addr_bit_seventeen_en_o,
    input wire logic [4:0] addr_pin_count_o
);
    logic [8:0] cfg_r;
    logic got_r;
    logic [1:0] map_w;
    assign map_w = cfg_r[3:2];
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            got_r <= 1'b0;
            cfg_r <= 9'h000;
        end else if (!got_r) begin
            got_r <= 1'b1;
            cfg_r <= {external_code_select_n_i, config_byte_zero_i};
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    chk_ale_addr: assert property (addr_latch_o |-> low_addr_data_bus_oe_o && high_addr_lines_oe_o
        && low_addr_data_bus_o == req_i.addr[7:0]) else $error("latch strobe without address");
    chk_ale_ready: assert property (addr_latch_o |-> ##[2:3] req_ready_o)
        else $error("bus cycle length wrong");
    chk_np_mux: assert property (got_r && cfg_r[1] && !write_strobe_n_o |-> low_addr_data_bus_o
        == req_i.wdata && high_addr_lines_o == req_i.addr[15:8]) else $error("nonpage lanes");
    chk_pg_mux: assert property (got_r && !cfg_r[1] && !write_strobe_n_o |-> high_addr_lines_o
        == req_i.wdata && low_addr_data_bus_o == req_i.addr[7:0]) else $error("page lanes");
    chk_wr_split: assert property (map_w == MAP_SPLIT && !write_strobe_n_o |-> req_i.addr
        <= WRITE_HIGH) else $error("write strobe out of range");
    chk_code_split: assert property (map_w == MAP_SPLIT && !code_read_strobe_n_o |-> req_i.addr
        >= CODE_READ_BASE) else $error("code strobe out of range");
    chk_port_pin: assert property (got_r && map_w == MAP_PORT |-> data_read_n_o == port3_bit7_i)
        else $error("port bit not shown");
    chk_pin_count: assert property (got_r |=> addr_pin_count_o == (map_w == MAP_A16 ? 5'h11 : 5'h10)
        && addr_bit_seventeen_en_o == (map_w == MAP_A16)) else $error("pin count");
    chk_onchip_src: assert property (onchip_o |-> cfg_r[8] && req_i.code)
        else $error("on chip service not allowed");
    chk_strobe_one: assert property (!code_read_strobe_n_o |=> code_read_strobe_n_o)
        else $error("code strobe too long");
    cover property (onchip_o);
    cover property (!write_strobe_n_o && !cfg_r[1]);
    cover property (req_ready_o && map_w == MAP_A16);
endmodule
bind embc_bus_ctrl embc_bus_ctrl_sva u_sva (.mclk_i, .reset_i, .config_byte_zero_i,
    .external_code_select_n_i, .req_i, .req_ready_o, .onchip_o, .port3_bit7_i,
    .low_addr_data_bus_o, .low_addr_data_bus_oe_o, .high_addr_lines_o, .high_addr_lines_oe_o,
    .addr_latch_o, .code_read_strobe_n_o, .data_read_n_o, .write_strobe_n_o,
    .addr_bit_seventeen_en_o, .addr_pin_count_o);

// ---- embc_cfg_latch.sv ----
// Purpose: capture interface options once at reset release
// Assumes: configuration byte and select strap are stable during reset
// Notes: options hold until the next reset
`timescale 1ns/1ps
module embc_cfg_latch
    import embc_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // straps
    input wire logic [7:0] config_byte_zero_i,
    input wire logic external_code_select_n_i,
    // captured options
    output embc_cfg_t cfg_o,
    output logic cfg_valid_o
);
    embc_cfg_t cfg_r, cfg_nxt;
    logic valid_r, valid_nxt;

    // async reset may load only constants, so capture on the first clocked edge
    always_comb begin
        cfg_nxt = cfg_r;
        valid_nxt = 1'b1;
        if (!valid_r) begin
            cfg_nxt.page_sel = config_byte_zero_i[CFG0_PAGE_BIT];
            cfg_nxt.read_map = {config_byte_zero_i[CFG0_READ_MAP_HI_BIT],
                                config_byte_zero_i[CFG0_READ_MAP_LO_BIT]};
            cfg_nxt.ext_code_only = ~external_code_select_n_i;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_r <= '{page_sel: CFG0_RESET[CFG0_PAGE_BIT], read_map: MAP_SPLIT,
                       ext_code_only: 1'b1};
            valid_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign cfg_o = cfg_r;
    assign cfg_valid_o = valid_r;
endmodule

// ---- embc_ext_mem.sv ----
// Purpose: external latch plus memory on the multiplexed bus
// Assumes: one shared array serves code and data, 17 address bits
// Notes: released lanes show the inverse of the last read byte
`timescale 1ns/1ps
module embc_ext_mem (
    input wire logic mclk_i,
    input wire logic page_i,
    input wire logic ale_i,
    input wire logic a16_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] p0_i,
    input wire logic [7:0] p2_i,
    output logic [7:0] p0_o,
    output logic [7:0] p2_o
);
    logic [7:0] mem [0:131071];
    logic [16:0] addr_r;
    logic [7:0] last_r = 8'h00;
    initial foreach (mem[i]) mem[i] = 8'(i * 7);
    always @(posedge mclk_i) begin
        if (ale_i) addr_r <= {a16_i, p2_i, p0_i};
        if (!wr_n_i) mem[addr_r] <= page_i ? p2_i : p0_i;
        if (!rd_n_i) last_r <= mem[addr_r];
    end
    assign p0_o = (!rd_n_i && !page_i) ? mem[addr_r] : ~last_r;
    assign p2_o = (!rd_n_i && page_i) ? mem[addr_r] : ~last_r;
endmodule

// ---- embc_pkg.sv ----
// Purpose: shared constants and types for the external memory bus controller
// Assumes: 100 MHz mclk_i; one oscillator period per mclk_i cycle
// Notes: configuration bytes are sampled once at reset release
package embc_pkg;
    localparam int OSC_PERIOD_NS = 10;
    localparam int STATE_NS = 2 * OSC_PERIOD_NS;
    localparam int CLK_NS = 10;
    localparam int STATE_CYC = (STATE_NS + CLK_NS - 1) / CLK_NS;
    localparam int NONPAGE_FETCH_NS = 4 * OSC_PERIOD_NS;
    localparam int PAGE_FETCH_NS = 2 * OSC_PERIOD_NS;
    localparam int NONPAGE_FETCH_CYC = (NONPAGE_FETCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int PAGE_FETCH_CYC = (PAGE_FETCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int CFG0_PAGE_BIT = 1;
    localparam int CFG0_READ_MAP_LO_BIT = 2;
    localparam int CFG0_READ_MAP_HI_BIT = 3;
    localparam logic [7:0] CFG0_RESET = 8'hFF;
    localparam logic [23:0] DATA_READ_TOP = 24'h7FFFFF;
    localparam logic [23:0] CODE_READ_BASE = 24'h800000;
    localparam logic [23:0] WRITE_LOW = 24'h000000;
    localparam logic [23:0] WRITE_HIGH = 24'h01FFFF;
    localparam logic [23:0] ONCHIP_CODE_BASE = 24'hFF0000;
    localparam logic [23:0] ONCHIP_CODE_TOP = 24'hFF3FFF;
    localparam logic [1:0] MAP_RESERVED = 2'h0;
    localparam logic [1:0] MAP_A16 = 2'h1;
    localparam logic [1:0] MAP_PORT = 2'h2;
    localparam logic [1:0] MAP_SPLIT = 2'h3;

    typedef struct packed {
        logic page_sel;
        logic [1:0] read_map;
        logic ext_code_only;
    } embc_cfg_t;

    typedef struct packed {
        logic code;
        logic write;
        logic [23:0] addr;
        logic [7:0] wdata;
    } embc_req_t;
endpackage

// ---- tb.sv ----
// Purpose: scenario bench for the external bus controller
// Assumes: straps move only under reset unless a scenario means otherwise
// Notes: bus cycle lengths counted in falling edges from the take edge
`timescale 1ns/1ps
module tb
    import embc_pkg::*;
;
    logic mclk_i, reset_i = 1'b1, req_valid_i = 1'b0, port3_bit7_i = 1'b1;
    logic external_code_select_n_i = 1'b0, page_q = 1'b0, req_ready_o, onchip_o;
    logic [7:0] config_byte_zero_i = 8'h0E, rdata_o, q;
    logic [1:0] map_q = MAP_SPLIT;
    embc_req_t req_i = '0;
    logic [7:0] low_addr_data_bus_o, low_addr_data_bus_i, high_addr_lines_o, high_addr_lines_i;
    logic low_addr_data_bus_oe_o, high_addr_lines_oe_o, addr_latch_o, code_read_strobe_n_o;
    logic data_read_n_o, write_strobe_n_o, addr_bit_seventeen_en_o, oc;
    logic [4:0] addr_pin_count_o;
    int n_fail = 0, samples_checked = 0, cyc = 0, n;
    embc_bus_ctrl u_dut (.mclk_i, .reset_i, .config_byte_zero_i, .external_code_select_n_i,
        .req_valid_i, .req_i, .req_ready_o, .onchip_o, .rdata_o, .port3_bit7_i,
        .low_addr_data_bus_o, .low_addr_data_bus_oe_o, .low_addr_data_bus_i,
        .high_addr_lines_o, .high_addr_lines_oe_o, .high_addr_lines_i, .addr_latch_o,
        .code_read_strobe_n_o, .data_read_n_o, .write_strobe_n_o, .addr_bit_seventeen_en_o,
        .addr_pin_count_o);
    embc_ext_mem u_mem (.mclk_i, .page_i(page_q), .ale_i(addr_latch_o),
        .a16_i(addr_bit_seventeen_en_o & data_read_n_o),
        .rd_n_i(code_read_strobe_n_o & (map_q != MAP_SPLIT | data_read_n_o)),
        .wr_n_i(write_strobe_n_o), .p0_i(low_addr_data_bus_o), .p2_i(high_addr_lines_o),
        .p0_o(low_addr_data_bus_i), .p2_o(high_addr_lines_i));
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    task stop_test;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            stop_test;
        end
    end
    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task restart(input logic [7:0] c, input logic e);
        @(posedge mclk_i);
        reset_i <= 1'b1;
        config_byte_zero_i <= c;
        external_code_select_n_i <= e;
        map_q <= c[3:2];
        page_q <= ~c[1];
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
    endtask
    // one request, held until ready; no parallel traffic, so no overlap hazard
    task xfer(input logic c, input logic w, input logic [23:0] a, input logic [7:0] d);
        n = -1; // the first falling edge still precedes the take edge
        req_i <= '{code: c, write: w, addr: a, wdata: d};
        req_valid_i <= 1'b1;
        do begin
            @(negedge mclk_i);
            n++;
        end while (req_ready_o !== 1'b1 && n < 50);
        q = rdata_o;
        oc = onchip_o;
        @(posedge mclk_i);
        req_valid_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task t_nonpage;
        restart(8'h0E, 1'b0);
        xfer(1'b0, 1'b1, 24'h01FFFF, 8'h3C);
        xfer(1'b0, 1'b1, 24'hFEFFFF, 8'hC3);
        xfer(1'b0, 1'b0, 24'h00FFFF, 8'h00);
        check("split data read", 8'h3C, q);
        xfer(1'b1, 1'b0, 24'hFFFFFF, 8'h00);
        check("code byte", 8'h3C, q);
        check("nonpage fetch cycles", NONPAGE_FETCH_CYC, n);
        check("fetch off chip", 1'b0, oc);
    endtask
    task t_page;
        restart(8'h0C, 1'b0);
        xfer(1'b0, 1'b1, 24'h001000, 8'h77);
        xfer(1'b1, 1'b0, 24'hFF1000, 8'h00);
        xfer(1'b1, 1'b0, 24'hFF1000, 8'h00);
        check("page code byte", 8'h77, q);
        check("page hit cycles", PAGE_FETCH_CYC, n);
    endtask
    task t_maps;
        restart(8'h06, 1'b0);
        check("pins map01", 5'h11, addr_pin_count_o);
        xfer(1'b0, 1'b1, 24'h010010, 8'h3C);
        xfer(1'b0, 1'b1, 24'h000010, 8'hC3);
        xfer(1'b0, 1'b0, 24'h010010, 8'h00);
        check("upper bank", 8'h3C, q);
        restart(8'h0A, 1'b0);
        check("pins map10", 5'h10, addr_pin_count_o);
        port3_bit7_i <= 1'b0;
        xfer(1'b0, 1'b1, 24'hFE2000, 8'h99);
        check("port bit low", 1'b0, data_read_n_o);
        port3_bit7_i <= 1'b1;
        xfer(1'b0, 1'b0, 24'h002000, 8'h00);
        check("write any address", 8'h99, q);
    endtask
    task t_onchip;
        restart(8'h0E, 1'b1);
        external_code_select_n_i <= 1'b0;
        config_byte_zero_i <= 8'h06;
        xfer(1'b1, 1'b0, 24'hFF0100, 8'h00);
        check("strap held", 1'b1, oc);
        check("options held", 5'h10, addr_pin_count_o);
        xfer(1'b1, 1'b0, 24'hFE0100, 8'h00);
        check("out of range off chip", 1'b0, oc);
        restart(8'h0E, 1'b0);
        xfer(1'b1, 1'b0, 24'hFF0100, 8'h00);
        check("all code off chip", 1'b0, oc);
    endtask
    initial begin
        t_nonpage;
        t_page;
        t_maps;
        t_onchip;
        stop_test;
    end
endmodule
